// ===== rtl/ppfs_map.svh
/*
 Register offsets, field positions and reset values of the port pin
 function select block. Assumes 8-bit byte addresses on an AXI4-Lite bus.
*/
`ifndef PPFS_MAP_SVH
`define PPFS_MAP_SVH

// =====================================================================
// register byte offsets
`define PPFS_OFF_DIR      8'h00
`define PPFS_OFF_ANSEL    8'h04
`define PPFS_OFF_LATCH    8'h08
`define PPFS_OFF_PULL     8'h0C
`define PPFS_OFF_IOCEN    8'h10
`define PPFS_OFF_BUFCTL   8'h14
`define PPFS_OFF_ADCCTL0  8'h18
`define PPFS_OFF_MODE     8'h1C
`define PPFS_OFF_OPTION   8'h20
`define PPFS_OFF_PINS     8'h24
`define PPFS_OFF_STATUS   8'h28
`define PPFS_OFF_CLEAR    8'h2C
`define PPFS_OFF_IRQEN    8'h30

// =====================================================================
// field positions
`define PPFS_BUF_MUXEN    0
`define PPFS_BUF_DSEL_LO  4
`define PPFS_OPT_TIMER0_CLOCK_SOURCE     0
`define PPFS_OPT_EXT_INT_ENABLE     1
`define PPFS_OPT_INTEDG   2
`define PPFS_ST_EXTINT    3

// =====================================================================
// reset values
`define PPFS_RST_DIR      4'hF
`define PPFS_RST_ANSEL    3'h0
`define PPFS_RST_LATCH    4'h0
`define PPFS_RST_PULL     3'h0
`define PPFS_RST_IOCEN    3'h0
`define PPFS_RST_BUFCTL   8'h00
`define PPFS_RST_ADCCTL0  6'h00
`define PPFS_RST_OPTION   3'h4

// =====================================================================
// bus responses
`define PPFS_RESP_OKAY    2'h0
`define PPFS_RESP_SLVERR  2'h2

`endif

// ===== rtl/ppfs_pkg.sv
/*
 Types of the port pin function select block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package ppfs_pkg;

   // =====================================================================
   // system configuration modes
   typedef enum logic [2:0] {
      PPFS_STANDALONE = 3'h0,
      PPFS_MO_MASTER  = 3'h1,
      PPFS_MO_SLAVE   = 3'h2,
      PPFS_MP_MASTER  = 3'h3,
      PPFS_MP_SLAVE   = 3'h4
   } ppfs_mode_e;

   // =====================================================================
   // bus channel states, gray along idle to answer
   typedef enum logic {
      PPFS_IDLE = 1'b0,
      PPFS_RESP = 1'b1
   } ppfs_bus_e;

endpackage

// ===== rtl/ppfs_pin_edge.sv
/*
 Change and edge detector for a group of pin levels.
 Assumes levels are already synchronous to ref_clk.
*/
`timescale 1ns/1ps
module ppfs_pin_edge #(
   parameter int WIDTH = 3
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             nrst,
   // levels in, pulses out
   input  wire logic [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] change,
   output logic      [WIDTH-1:0] rise,
   output logic      [WIDTH-1:0] fall
);

   logic [WIDTH-1:0] prev_reg;
   logic             armed_reg;

   // =====================================================================
   // previous level; first cycle after reset is not armed, so a pin
   // that sits high through reset raises no false change
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         prev_reg  <= '0;
         armed_reg <= 1'b0;
      end else begin
         prev_reg  <= level;
         armed_reg <= 1'b1;
      end
   end

   // pulses are combinational, one cycle each
   assign change = armed_reg ? (level ^ prev_reg) : '0;
   assign rise   = armed_reg ? (level & ~prev_reg) : '0;
   assign fall   = armed_reg ? (~level & prev_reg) : '0;

endmodule

// ===== rtl/ppfs_top.sv
/*
 Port A pin function select with sync and switching clock remap,
 behind an AXI4-Lite register slave, with interrupt-on-change.
 Assumes pin inputs synchronous to ref_clk and the pad ring resolving
 level, pull and analog switch from the enables given here.
*/
// Notes on behaviour
// - each of pins 0..2 takes its direction from its own direction bit
// - pins 0 and 1 have optional weak pull-up and change interrupt
// - pin 2 has optional weak current source and change interrupt
// - converter channel n connects only when direction and analog bits set
// - mux output enable drives pin 0 with buffered test multiplexer output
// - analog mux source from adc control, digital source from buffer control
// - in master or slave modes pin 1 carries sync, out as master
// - port b pin 3 carries switching clock in master or slave modes
// - timer0 clock source bit routes pin 2 to timer0 external clock
// - external interrupt enable makes pin 2 an interrupt source
`timescale 1ns/1ps
`include "ppfs_map.svh"
module ppfs_top #(
   parameter int PINS      = 3,
   parameter int DIG_SEL_W = 4
) (
   // clock and reset
   input  wire logic                      ref_clk,
   input  wire logic                      nrst,
   // axi4-lite write channels
   input  wire logic [7:0]                awaddr,
   input  wire logic                      awvalid,
   output logic                           awready,
   input  wire logic [31:0]               wdata,
   input  wire logic [3:0]                wstrb,
   input  wire logic                      wvalid,
   output logic                           wready,
   output logic [1:0]                     bresp,
   output logic                           bvalid,
   input  wire logic                      bready,
   // axi4-lite read channels
   input  wire logic [7:0]                araddr,
   input  wire logic                      arvalid,
   output logic                           arready,
   output logic [31:0]                    rdata,
   output logic [1:0]                     rresp,
   output logic                           rvalid,
   input  wire logic                      rready,
   // port a pins
   input  wire logic [PINS-1:0]           portAIn,
   output logic      [PINS-1:0]           portAOut,
   output logic      [PINS-1:0]           portAOe,
   // port b pin 3
   input  wire logic                      portB3In,
   output logic                           portB3Out,
   output logic                           portB3Oe,
   // pad controls
   output logic      [1:0]                pullUpEn,
   output logic                           currentSrcEn,
   output logic      [PINS-1:0]           adcConnect,
   // test multiplexer
   input  wire logic [2**DIG_SEL_W-1:0]   testMuxDigIn,
   output logic      [5:0]                testMuxAnaSel,
   output logic                           testMuxAnalogOn,
   // converter core sync and clock
   input  wire logic                      syncFromCore,
   output logic                           syncToCore,
   input  wire logic                      swClkFromCore,
   output logic                           swClkToCore,
   // timer and interrupt
   output logic                           timer0ExtClkIn,
   output logic                           irq
);

   // =====================================================================
   // registers
   logic [3:0]           dir_reg;      // bit3 is port b pin 3
   logic [PINS-1:0]      ansel_reg;
   logic [3:0]           latch_reg;
   logic [PINS-1:0]      pull_reg;
   logic [PINS-1:0]      iocEn_reg;
   logic [7:0]           bufCtl_reg;
   logic [5:0]           adcCtl_reg;
   ppfs_pkg::ppfs_mode_e mode_reg;
   logic [2:0]           option_reg;
   logic [3:0]           status_reg;
   logic [3:0]           irqEn_reg;

   // bus state
   ppfs_pkg::ppfs_bus_e  wState_reg;
   ppfs_pkg::ppfs_bus_e  rState_reg;
   logic                 awHave_reg;
   logic                 wHave_reg;
   logic [7:0]           awAddr_reg;
   logic [31:0]          wData_reg;
   logic                 wLane_reg;
   logic                 doWrite;
   logic [31:0]          rdata_next;
   logic [1:0]           rresp_next;

   // pin logic
   logic [PINS-1:0]      change;
   logic [PINS-1:0]      rise;
   logic [PINS-1:0]      fall;
   logic                 testMuxBit;
   logic                 master;
   logic                 slave;
   logic [3:0]           events;
   logic [3:0]           clrMask;

   // =====================================================================
   // functions
   function automatic logic isMaster(input ppfs_pkg::ppfs_mode_e m);
      isMaster = (m == ppfs_pkg::PPFS_MO_MASTER) || (m == ppfs_pkg::PPFS_MP_MASTER);
   endfunction

   function automatic logic isSlave(input ppfs_pkg::ppfs_mode_e m);
      isSlave = (m == ppfs_pkg::PPFS_MO_SLAVE) || (m == ppfs_pkg::PPFS_MP_SLAVE);
   endfunction

   function automatic logic wrHit(input logic [7:0] off);
      wrHit = doWrite && wLane_reg && (awAddr_reg == off);
   endfunction

   // =====================================================================
   // write channel: address and data taken in either order, one at a time
   assign awready = (wState_reg == ppfs_pkg::PPFS_IDLE) && !awHave_reg;
   assign wready  = (wState_reg == ppfs_pkg::PPFS_IDLE) && !wHave_reg;
   assign doWrite = (wState_reg == ppfs_pkg::PPFS_IDLE) && awHave_reg && wHave_reg;
   assign bvalid  = (wState_reg == ppfs_pkg::PPFS_RESP);

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         wState_reg <= ppfs_pkg::PPFS_IDLE;
         awHave_reg <= 1'b0;
         wHave_reg  <= 1'b0;
         awAddr_reg <= 8'h00;
         wData_reg  <= 32'h0000_0000;
         wLane_reg  <= 1'b0;
         bresp      <= `PPFS_RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            awHave_reg <= 1'b1;
            awAddr_reg <= awaddr;
         end
         if (wvalid && wready) begin
            wHave_reg <= 1'b1;
            wData_reg <= wdata;
            wLane_reg <= wstrb[0];
         end
         unique case (wState_reg)
            ppfs_pkg::PPFS_IDLE: begin
               if (doWrite) begin
                  awHave_reg <= 1'b0;
                  wHave_reg  <= 1'b0;
                  wState_reg <= ppfs_pkg::PPFS_RESP;
                  // read-only pin and status words refuse writes
                  if (awAddr_reg > `PPFS_OFF_IRQEN || awAddr_reg[1:0] != 2'h0 ||
                      awAddr_reg == `PPFS_OFF_PINS || awAddr_reg == `PPFS_OFF_STATUS)
                     bresp <= `PPFS_RESP_SLVERR;
                  else
                     bresp <= `PPFS_RESP_OKAY;
               end
            end
            ppfs_pkg::PPFS_RESP: begin
               if (bready)
                  wState_reg <= ppfs_pkg::PPFS_IDLE;
            end
         endcase
      end
   end

   // =====================================================================
   // configuration registers; only byte lane 0 holds data
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         dir_reg    <= `PPFS_RST_DIR;
         ansel_reg  <= `PPFS_RST_ANSEL;
         latch_reg  <= `PPFS_RST_LATCH;
         pull_reg   <= `PPFS_RST_PULL;
         iocEn_reg  <= `PPFS_RST_IOCEN;
         bufCtl_reg <= `PPFS_RST_BUFCTL;
         adcCtl_reg <= `PPFS_RST_ADCCTL0;
         mode_reg   <= ppfs_pkg::PPFS_STANDALONE;
         option_reg <= `PPFS_RST_OPTION;
         irqEn_reg  <= 4'h0;
      end else begin
         if (wrHit(`PPFS_OFF_DIR))     dir_reg    <= wData_reg[3:0];
         if (wrHit(`PPFS_OFF_ANSEL))   ansel_reg  <= wData_reg[PINS-1:0];
         if (wrHit(`PPFS_OFF_LATCH))   latch_reg  <= wData_reg[3:0];
         if (wrHit(`PPFS_OFF_PULL))    pull_reg   <= wData_reg[PINS-1:0];
         if (wrHit(`PPFS_OFF_IOCEN))   iocEn_reg  <= wData_reg[PINS-1:0];
         if (wrHit(`PPFS_OFF_BUFCTL))  bufCtl_reg <= wData_reg[7:0];
         if (wrHit(`PPFS_OFF_ADCCTL0)) adcCtl_reg <= wData_reg[5:0];
         if (wrHit(`PPFS_OFF_OPTION))  option_reg <= wData_reg[2:0];
         if (wrHit(`PPFS_OFF_IRQEN))   irqEn_reg  <= wData_reg[3:0];
         // reserved mode codes fall back to standalone
         if (wrHit(`PPFS_OFF_MODE)) begin
            if (wData_reg[2:0] > 3'h4)
               mode_reg <= ppfs_pkg::PPFS_STANDALONE;
            else
               mode_reg <= ppfs_pkg::ppfs_mode_e'(wData_reg[2:0]);
         end
      end
   end

   // =====================================================================
   // read channel: answer one cycle after the address is taken
   assign arready = (rState_reg == ppfs_pkg::PPFS_IDLE);
   assign rvalid  = (rState_reg == ppfs_pkg::PPFS_RESP);

   always_comb begin
      rdata_next = 32'h0000_0000;
      rresp_next = `PPFS_RESP_OKAY;
      unique case (araddr)
         `PPFS_OFF_DIR:     rdata_next[3:0]      = dir_reg;
         `PPFS_OFF_ANSEL:   rdata_next[PINS-1:0] = ansel_reg;
         `PPFS_OFF_LATCH:   rdata_next[3:0]      = latch_reg;
         `PPFS_OFF_PULL:    rdata_next[PINS-1:0] = pull_reg;
         `PPFS_OFF_IOCEN:   rdata_next[PINS-1:0] = iocEn_reg;
         `PPFS_OFF_BUFCTL:  rdata_next[7:0]      = bufCtl_reg;
         `PPFS_OFF_ADCCTL0: rdata_next[5:0]      = adcCtl_reg;
         `PPFS_OFF_MODE:    rdata_next[2:0]      = mode_reg;
         `PPFS_OFF_OPTION:  rdata_next[2:0]      = option_reg;
         `PPFS_OFF_PINS:    rdata_next[3:0]      = {portB3In, portAIn};
         `PPFS_OFF_STATUS:  rdata_next[3:0]      = status_reg;
         `PPFS_OFF_CLEAR:   rdata_next           = 32'h0000_0000;
         `PPFS_OFF_IRQEN:   rdata_next[3:0]      = irqEn_reg;
         default:           rresp_next           = `PPFS_RESP_SLVERR;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         rState_reg <= ppfs_pkg::PPFS_IDLE;
         rdata      <= 32'h0000_0000;
         rresp      <= `PPFS_RESP_OKAY;
      end else begin
         unique case (rState_reg)
            ppfs_pkg::PPFS_IDLE: begin
               if (arvalid) begin
                  rdata      <= rdata_next;
                  rresp      <= rresp_next;
                  rState_reg <= ppfs_pkg::PPFS_RESP;
               end
            end
            ppfs_pkg::PPFS_RESP: begin
               if (rready)
                  rState_reg <= ppfs_pkg::PPFS_IDLE;
            end
         endcase
      end
   end

   // =====================================================================
   // pad controls
   assign master = isMaster(mode_reg);
   assign slave  = isSlave(mode_reg);
   assign pullUpEn     = pull_reg[1:0] & dir_reg[1:0];
   assign currentSrcEn = pull_reg[2] & dir_reg[2];
   assign adcConnect   = dir_reg[PINS-1:0] & ansel_reg;

   // analog source from adc control, digital from buffer control
   assign testMuxAnaSel   = adcCtl_reg;
   assign testMuxAnalogOn = bufCtl_reg[`PPFS_BUF_MUXEN];
   assign testMuxBit = testMuxDigIn[bufCtl_reg[`PPFS_BUF_DSEL_LO +: DIG_SEL_W]];

   // =====================================================================
   // pin drivers; registered so every pad sees a clean edge
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         portAOut  <= '0;
         portAOe   <= '0;
         portB3Out <= 1'b0;
         portB3Oe  <= 1'b0;
      end else begin
         // direction bit low drives the latch
         portAOut <= latch_reg[PINS-1:0];
         portAOe  <= ~dir_reg[PINS-1:0];
         portB3Out <= latch_reg[3];
         portB3Oe  <= ~dir_reg[3];
         if (bufCtl_reg[`PPFS_BUF_MUXEN]) begin
            portAOut[0] <= testMuxBit;
            portAOe[0]  <= 1'b1;
         end
         // sync driven as master, received as slave
         if (master) begin
            portAOut[1] <= syncFromCore;
            portAOe[1]  <= 1'b1;
         end else if (slave) begin
            portAOe[1] <= 1'b0;
         end
         // switching clock on port b pin 3
         if (master) begin
            portB3Out <= swClkFromCore;
            portB3Oe  <= 1'b1;
         end else if (slave) begin
            portB3Oe <= 1'b0;
         end
      end
   end

   // =====================================================================
   // inputs towards the core; low outside their modes so no stray edges
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         syncToCore     <= 1'b0;
         swClkToCore    <= 1'b0;
         timer0ExtClkIn <= 1'b0;
      end else begin
         syncToCore  <= slave & portAIn[1];
         swClkToCore <= slave & portB3In;
         // pin 2 clocks timer0, schmitt input assumed in the pad
         timer0ExtClkIn <= option_reg[`PPFS_OPT_TIMER0_CLOCK_SOURCE] & portAIn[2];
      end
   end

   // =====================================================================
   // change detection and interrupt status
   ppfs_pin_edge #(
      .WIDTH (PINS)
   ) u_edge (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .level   (portAIn),
      .change  (change),
      .rise    (rise),
      .fall    (fall)
   );

   // change interrupt on pins 0 to 2
   assign events[PINS-1:0] = change & iocEn_reg;
   // pin 2 external interrupt on the chosen edge
   assign events[`PPFS_ST_EXTINT] = option_reg[`PPFS_OPT_EXT_INT_ENABLE] &
      (option_reg[`PPFS_OPT_INTEDG] ? rise[2] : fall[2]);
   // a process, not an assign: the bus state that the decode reads must wake it
   always_comb clrMask = wrHit(`PPFS_OFF_CLEAR) ? wData_reg[3:0] : 4'h0;

   // sticky status; a set in the clear cycle wins so no event is lost
   always_ff @(posedge ref_clk) begin
      if (!nrst)
         status_reg <= 4'h0;
      else
         status_reg <= (status_reg & ~clrMask) | events;
   end

   assign irq = |(status_reg & irqEn_reg);

   // =====================================================================
   // assertions
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   sequence s_ext_edge;
      option_reg[`PPFS_OPT_EXT_INT_ENABLE] && option_reg[`PPFS_OPT_INTEDG] && rise[2];
   endsequence

   sequence s_flag_set;
      ##1 status_reg[`PPFS_ST_EXTINT];
   endsequence

   a_pin2_direction: assert property (
      dir_reg[2] |=> !portAOe[2]) else $error("pin 2 driven while input");
   a_pin0_ioc_flag: assert property (
      (iocEn_reg[0] && change[0]) |=> status_reg[0]) else $error("pin 0 change lost");
   a_pin2_no_pull: assert property (
      currentSrcEn |-> (pull_reg[2] && dir_reg[2])) else $error("current source wrong");
   a_adc_connect: assert property (
      adcConnect[1] |-> (dir_reg[1] && ansel_reg[1])) else $error("channel 1 connected");
   a_testmux_drive: assert property (
      testMuxAnalogOn |=> (portAOe[0] && portAOut[0] == $past(testMuxBit)))
      else $error("test mux not on pin 0");
   a_testmux_source: assert property (
      testMuxAnalogOn |-> testMuxAnaSel == adcCtl_reg) else $error("analog source wrong");
   a_sync_master: assert property (
      master |=> (portAOe[1] && portAOut[1] == $past(syncFromCore)))
      else $error("sync not driven");
   a_clock_slave: assert property (
      slave |=> (!portB3Oe && swClkToCore == $past(portB3In)))
      else $error("clock not received");
   a_timer0_route: assert property (
      option_reg[`PPFS_OPT_TIMER0_CLOCK_SOURCE] |=> timer0ExtClkIn == $past(portAIn[2]))
      else $error("timer0 clock not routed");
   a_ext_int_flag: assert property (
      s_ext_edge |-> s_flag_set) else $error("external interrupt lost");
   a_alt_override: assert property (
      (master && latch_reg[1] != syncFromCore) |=> portAOut[1] != $past(latch_reg[1]))
      else $error("latch beat sync output");

endmodule

// ===== tb/ppfs_board_model.sv
/*
 Board-side model of the port pins: resolves the level seen on each pin.
 Assumes the bench sets which lines the board drives and to what level.
*/
`timescale 1ns/1ps
module ppfs_board_model (
   // clock
   input  wire logic       ref_clk,
   // block side
   input  wire logic [2:0] portAOut,
   input  wire logic [2:0] portAOe,
   input  wire logic       portB3Out,
   input  wire logic       portB3Oe,
   input  wire logic [1:0] pullUpEn,
   input  wire logic       currentSrcEn,
   // bench side
   input  wire logic [3:0] extDrive,
   input  wire logic [3:0] extLevel,
   // resolved levels
   output logic      [2:0] portAIn,
   output logic            portB3In
);
   logic       floatPat = 1'b0;
   logic [2:0] weakOn;

   // a floating line wanders, so a stale level never passes for a real one
   always_ff @(posedge ref_clk) begin
      floatPat <= ~floatPat;
   end

   assign weakOn = {currentSrcEn, pullUpEn};

   // driver, board, then weak pull or source
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         if (portAOe[i]) portAIn[i] = portAOut[i];
         else if (extDrive[i]) portAIn[i] = extLevel[i];
         else portAIn[i] = weakOn[i] ? 1'b1 : floatPat;
      end
      portB3In = portB3Oe ? portB3Out : (extDrive[3] ? extLevel[3] : floatPat);
   end
endmodule

// ===== tb/test_port_pin_function_select.sv
/*
 Self-checking bench of the pin function select block over AXI4-Lite.
 Assumes the register map header and the board model beside it.
*/
`timescale 1ns/1ps
`include "ppfs_map.svh"
module test_port_pin_function_select;
   localparam logic [1:0] OK = `PPFS_RESP_OKAY;
   localparam logic [1:0] SE = `PPFS_RESP_SLVERR;
   logic        ref_clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, portB3In, portB3Out, portB3Oe;
   logic        currentSrcEn, testMuxAnalogOn, syncFromCore, syncToCore;
   logic        swClkFromCore, swClkToCore, timer0ExtClkIn, irq, ms;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb, extDrive, extLevel;
   logic [1:0]  bresp, rresp, pullUpEn;
   logic [2:0]  portAIn, portAOut, portAOe, adcConnect;
   logic [15:0] testMuxDigIn;
   logic [5:0]  testMuxAnaSel;
   int          failures, num_checks, cycles;
   logic [7:0]  offs [11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
                              8'h20, 8'h28, 8'h30};
   logic [31:0] rstv [11] = '{32'hF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
                              32'h4, 32'h0, 32'h0};

   ppfs_top dut (.ref_clk, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .portAIn, .portAOut, .portAOe, .portB3In, .portB3Out, .portB3Oe,
      .pullUpEn, .currentSrcEn, .adcConnect, .testMuxDigIn, .testMuxAnaSel,
      .testMuxAnalogOn, .syncFromCore, .syncToCore, .swClkFromCore, .swClkToCore,
      .timer0ExtClkIn, .irq);

   ppfs_board_model board (.ref_clk, .portAOut, .portAOe, .portB3Out, .portB3Oe,
      .pullUpEn, .currentSrcEn, .extDrive, .extLevel, .portAIn, .portB3In);

   // =====================================================================
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // ready is sampled mid-cycle, where it already holds its value for the next edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      logic awT, wT, bT;
      logic [1:0] r;
      bT = 1'b0;
      @(posedge ref_clk);
      awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
      // no wait limit here: only the watchdog ends a hung transfer
      while (!bT) begin
         @(negedge ref_clk);
         awT = awvalid & awready; wT = wvalid & wready; bT = bvalid & bready; r = bresp;
         @(posedge ref_clk);
         if (awT) awvalid <= 1'b0;
         if (wT) wvalid <= 1'b0;
         if (bT) bready <= 1'b0;
      end
      chk({30'h0, r}, {30'h0, e});
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] e);
      logic arT, rT;
      logic [31:0] d;
      logic [1:0] r;
      rT = 1'b0;
      @(posedge ref_clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      while (!rT) begin
         @(negedge ref_clk);
         arT = arvalid & arready; rT = rvalid & rready; d = rdata; r = rresp;
         @(posedge ref_clk);
         if (arT) arvalid <= 1'b0;
         if (rT) rready <= 1'b0;
      end
      chk(d, ed);
      chk({30'h0, r}, {30'h0, e});
   endtask

   task automatic pins(input logic [3:0] dr, input logic [3:0] lv, input int w);
      @(posedge ref_clk);
      extDrive <= dr;
      extLevel <= lv;
      repeat (w) @(negedge ref_clk);
   endtask

   task automatic stop_test();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // =====================================================================
   // clock and watchdog; the whole run needs well under two thousand cycles
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         stop_test();
      end
   end

   // =====================================================================
   // main sequence
   initial begin
      nrst = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
      rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hF;
      extDrive = 4'hF; extLevel = 4'h0; testMuxDigIn = 16'h0008;
      syncFromCore = 1'b1; swClkFromCore = 1'b1;
      repeat (8) @(posedge ref_clk);
      nrst <= 1'b1;
      for (int i = 0; i < 11; i++) rd(offs[i], rstv[i], OK);
      rd(8'h34, 32'h0, SE);
      wr(`PPFS_OFF_PINS, 32'h1, SE);
      wr(`PPFS_OFF_DIR, 32'h0, OK);
      wr(`PPFS_OFF_LATCH, 32'h5, OK);
      pins(4'hF, 4'h0, 2);
      chk(portAOe, 3'h7);
      chk(portAOut, 3'h5);
      wr(`PPFS_OFF_ANSEL, 32'h7, OK);
      pins(4'hF, 4'h0, 2);
      chk(adcConnect, 3'h0);
      wr(`PPFS_OFF_DIR, 32'hE, OK);
      pins(4'hF, 4'h0, 2);
      chk(adcConnect, 3'h6);
      rd(`PPFS_OFF_PINS, 32'h1, OK);
      wr(`PPFS_OFF_PULL, 32'h7, OK);
      pins(4'h9, 4'h0, 3);
      chk({pullUpEn, currentSrcEn}, 3'h5);
      rd(`PPFS_OFF_PINS, 32'h7, OK);
      wr(`PPFS_OFF_LATCH, 32'h0, OK);
      wr(`PPFS_OFF_BUFCTL, 32'h31, OK);
      wr(`PPFS_OFF_ADCCTL0, 32'h2A, OK);
      pins(4'hF, 4'h0, 2);
      chk({portAOe[0], portAOut[0], testMuxAnalogOn}, 3'h7);
      chk(testMuxAnaSel, 6'h2A);
      wr(`PPFS_OFF_BUFCTL, 32'h21, OK);
      pins(4'hF, 4'h0, 2);
      chk(portAOut[0], 1'b0);
      wr(`PPFS_OFF_BUFCTL, 32'h0, OK);
      // master drives sync and clock out, slave hands the board levels in
      for (int m = 1; m < 5; m++) begin
         ms = (m == 1 || m == 3);
         wr(`PPFS_OFF_MODE, m, OK);
         pins(4'hF, 4'hA, 3);
         chk({portAOe[1], portAOe[1] & portAOut[1], syncToCore}, ms ? 3'h6 : 3'h1);
         chk({portB3Oe, portB3Oe & portB3Out, swClkToCore}, ms ? 3'h6 : 3'h1);
      end
      wr(`PPFS_OFF_MODE, 32'h7, OK);
      rd(`PPFS_OFF_MODE, 32'h0, OK);
      wr(`PPFS_OFF_OPTION, 32'h1, OK);
      pins(4'hF, 4'h4, 3);
      chk(timer0ExtClkIn, 1'b1);
      pins(4'hF, 4'h0, 3);
      chk(timer0ExtClkIn, 1'b0);
      wr(`PPFS_OFF_OPTION, 32'h6, OK);
      wr(`PPFS_OFF_IRQEN, 32'h8, OK);
      pins(4'hF, 4'h4, 3);
      chk(irq, 1'b1);
      rd(`PPFS_OFF_STATUS, 32'h8, OK);
      wr(`PPFS_OFF_IRQEN, 32'h0, OK);
      chk(irq, 1'b0);
      wr(`PPFS_OFF_CLEAR, 32'h8, OK);
      pins(4'hF, 4'h0, 3);
      rd(`PPFS_OFF_STATUS, 32'h0, OK);
      // falling edge choice: a rise must not flag, a fall must
      wr(`PPFS_OFF_OPTION, 32'h2, OK);
      pins(4'hF, 4'h4, 3);
      chk(timer0ExtClkIn, 1'b0);
      rd(`PPFS_OFF_STATUS, 32'h0, OK);
      pins(4'hF, 4'h0, 3);
      rd(`PPFS_OFF_STATUS, 32'h8, OK);
      wr(`PPFS_OFF_CLEAR, 32'h8, OK);
      wr(`PPFS_OFF_IOCEN, 32'h7, OK);
      wr(`PPFS_OFF_IRQEN, 32'h7, OK);
      pins(4'hF, 4'h2, 3);
      chk(irq, 1'b1);
      rd(`PPFS_OFF_STATUS, 32'h2, OK);
      wr(`PPFS_OFF_CLEAR, 32'h7, OK);
      chk(irq, 1'b0);
      stop_test();
   end
endmodule
